// ==== pco_preset_count_output.sv ====
module pco_preset_count_output
    import pco_pkg::*;
#(
    parameter int CYC_PER_MS = PCO_CYC_PER_MS
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [pco_pkg::PCO_AW-1:0] reg_addr,
    input wire logic [pco_pkg::PCO_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pco_pkg::PCO_DW-1:0] reg_rdata,
    input wire logic count_tick,
    input wire logic external_control_input,
    input wire logic [pco_pkg::PCO_DW-1:0] nv_total_in,
    input wire logic nv_total_load,
    output logic [pco_pkg::PCO_DW-1:0] nv_total_out,
    output logic nv_total_write,
    output logic contact_output_one,
    output logic contact_output_two
);
    import pco_pkg::*;

    // ==========================================================
    // address decode helper
    function automatic logic addr_hit(input logic [PCO_AW-1:0] a, input logic [7:0] off);
        addr_hit = (a == off);
    endfunction

    // ==========================================================
    // declarations
    logic [PCO_CTRL_W-1:0] ctrl_r;
    logic [PCO_CTRL_W-1:0] ctrl_nxt;
    logic [PCO_DW-1:0] preset_count_r;
    logic [PCO_DW-1:0] preset_count_nxt;
    logic [15:0] pulse_width_r;
    logic [15:0] pulse_width_nxt;
    logic [PCO_DW-1:0] total_r;
    logic [PCO_DW-1:0] total_nxt;
    logic [PCO_DW-1:0] point_r;
    logic [PCO_DW-1:0] point_nxt;
    logic [PCO_DW-1:0] point_sum;
    logic running_r;
    logic running_nxt;
    logic level_out_r;
    logic level_out_nxt;
    logic out_one_r;
    logic out_two_r;
    logic nv_write_r;
    logic [PCO_DW-1:0] rdata_r;
    logic [PCO_DW-1:0] rdata_nxt;

    logic sel_ctrl;
    logic sel_cmd;
    logic sel_count;
    logic sel_width;
    logic sel_total;
    logic sel_point;
    logic sel_status;
    logic wr_ctrl;
    logic wr_cmd;
    logic wr_count;
    logic wr_width;

    pco_mode_e mode;
    logic out_sel_two;
    logic [1:0] func_sel;
    logic pol_high;
    logic ctl_level;
    logic ext_clear_active;
    logic local_clear;
    logic local_start;
    logic local_stop;
    logic any_clear;
    logic counting;
    logic reached;
    logic shot_fire;
    logic shot_active;
    logic preset_out;
    logic [PCO_DW-1:0] status_word;

    // ==========================================================
    // external control input crosses in through two flops
    pco_sync u_ctl_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin_in(external_control_input),
        .level_out(ctl_level)
    );

    // ==========================================================
    // register select lines
    assign sel_ctrl = addr_hit(reg_addr, PCO_OFF_CTRL);
    assign sel_cmd = addr_hit(reg_addr, PCO_OFF_CMD);
    assign sel_count = addr_hit(reg_addr, PCO_OFF_PRESET_COUNT);
    assign sel_width = addr_hit(reg_addr, PCO_OFF_PULSE_WIDTH);
    assign sel_total = addr_hit(reg_addr, PCO_OFF_TOTAL);
    assign sel_point = addr_hit(reg_addr, PCO_OFF_PRESET_POINT);
    assign sel_status = addr_hit(reg_addr, PCO_OFF_STATUS);

    // write enables per register
    assign wr_ctrl = reg_wr && sel_ctrl;
    assign wr_cmd = reg_wr && sel_cmd;
    assign wr_count = reg_wr && sel_count;
    assign wr_width = reg_wr && sel_width;

    // ==========================================================
    // control fields
    assign mode = pco_mode_e'(ctrl_r[PCO_CTRL_MODE_BIT]);
    assign out_sel_two = ctrl_r[PCO_CTRL_OUTSEL_BIT];
    assign func_sel = ctrl_r[PCO_CTRL_FUNC_LSB +: PCO_CTRL_FUNC_W];
    assign pol_high = ctrl_r[PCO_CTRL_POL_BIT];

    // configuration register next values
    assign ctrl_nxt = wr_ctrl ? reg_wdata[PCO_CTRL_W-1:0] : ctrl_r;
    assign preset_count_nxt = wr_count ? reg_wdata : preset_count_r;
    assign pulse_width_nxt = wr_width ? reg_wdata[15:0] : pulse_width_r;

    // configuration registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= PCO_CTRL_RESET;
            preset_count_r <= PCO_PRESET_COUNT_RESET;
            pulse_width_r <= PCO_PULSE_WIDTH_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
            preset_count_r <= preset_count_nxt;
            pulse_width_r <= pulse_width_nxt;
        end
    end

    // ==========================================================
    // local operation switch commands, one-cycle pulses
    assign local_clear = wr_cmd && reg_wdata[PCO_CMD_CLEAR_BIT];
    assign local_start = wr_cmd && reg_wdata[PCO_CMD_START_BIT];
    assign local_stop = wr_cmd && reg_wdata[PCO_CMD_STOP_BIT];

    // ==========================================================
    // external clear/hold: polarity picks which level clears
    // ignored unless the input serves as clear/run control
    assign ext_clear_active = (func_sel == PCO_FUNC_CLEAR_RUN) &&
                              (pol_high ? ctl_level : !ctl_level);

    // either source clears the total the same way
    assign any_clear = ext_clear_active || local_clear;

    // ==========================================================
    // run/stop state from the local switch
    // a stop wins over a start written in the same word
    assign running_nxt = local_stop ? 1'b0 :
                         local_start ? 1'b1 :
                         running_r;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            running_r <= 1'b1;
        end else begin
            running_r <= running_nxt;
        end
    end

    // counting needs run state and no external hold
    assign counting = running_r && !ext_clear_active && count_tick;

    // ==========================================================
    // running total, restored from nonvolatile storage on load
    // a clear holds it at zero for as long as it lasts
    assign total_nxt = any_clear ? '0 :
                       nv_total_load ? nv_total_in :
                       counting ? total_r + 32'h0000_0001 :
                       total_r;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            total_r <= '0;
        end else begin
            total_r <= total_nxt;
        end
    end

    // ==========================================================
    // every change of the total, except a load from storage, is pushed to storage
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            nv_write_r <= 1'b0;
        end else begin
            nv_write_r <= (total_nxt != total_r) && !nv_total_load;
        end
    end

    assign nv_total_out = total_r;
    assign nv_total_write = nv_write_r;

    // ==========================================================
    // preset point comparison
    assign reached = (total_r >= point_r) && !any_clear;

    // one-shot fires once per arrival; level mode only latches
    assign shot_fire = reached && (mode == PCO_MODE_ONESHOT);

    // next target is current point plus the preset count
    assign point_sum = point_r + preset_count_r;

    // point returns to one preset count on clear or new count
    assign point_nxt = (any_clear || wr_count) ? preset_count_nxt :
                       shot_fire ? point_sum :
                       point_r;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            point_r <= PCO_PRESET_COUNT_RESET;
        end else begin
            point_r <= point_nxt;
        end
    end

    // ==========================================================
    // level-hold latch: set on arrival, dropped by a clear or by leaving level mode
    assign level_out_nxt = any_clear ? 1'b0 :
                           (reached && mode == PCO_MODE_LEVEL) ? 1'b1 :
                           (mode == PCO_MODE_LEVEL) ? level_out_r :
                           1'b0;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            level_out_r <= 1'b0;
        end else begin
            level_out_r <= level_out_nxt;
        end
    end

    // ==========================================================
    // one-shot width timer; a new arrival restarts it, so a
    // width longer than the arrival spacing stays on
    pco_pulse_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_shot (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(shot_fire),
        .cancel(any_clear || mode == PCO_MODE_LEVEL),
        .width_ms(pulse_width_r),
        .active(shot_active)
    );

    // ==========================================================
    // preset output from the active mode
    assign preset_out = (mode == PCO_MODE_ONESHOT) ? shot_active : level_out_r;

    // route to the chosen contact output, registered
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            out_one_r <= 1'b0;
            out_two_r <= 1'b0;
        end else begin
            out_one_r <= preset_out && !out_sel_two;
            out_two_r <= preset_out && out_sel_two;
        end
    end

    assign contact_output_one = out_one_r;
    assign contact_output_two = out_two_r;

    // ==========================================================
    // status word
    assign status_word = {
        28'h000_0000,
        shot_active,
        ext_clear_active,
        running_r,
        preset_out
    };

    // read multiplexer; unmapped and command offsets read zero
    assign rdata_nxt = !reg_rd ? '0 :
                       sel_ctrl ? {27'h000_0000, ctrl_r} :
                       sel_count ? preset_count_r :
                       sel_width ? {16'h0000, pulse_width_r} :
                       sel_total ? total_r :
                       sel_point ? point_r :
                       sel_status ? status_word :
                       '0;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

endmodule

// ==== pco_pkg.sv ====
package pco_pkg;

    // ==========================================================
    // register bus geometry
    localparam int PCO_AW = 8;
    localparam int PCO_DW = 32;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] PCO_OFF_CTRL = 8'h00;
    localparam logic [7:0] PCO_OFF_CMD = 8'h04;
    localparam logic [7:0] PCO_OFF_PRESET_COUNT = 8'h08;
    localparam logic [7:0] PCO_OFF_PULSE_WIDTH = 8'h0C;
    localparam logic [7:0] PCO_OFF_TOTAL = 8'h10;
    localparam logic [7:0] PCO_OFF_PRESET_POINT = 8'h14;
    localparam logic [7:0] PCO_OFF_STATUS = 8'h18;

    // ==========================================================
    // control register fields
    localparam int PCO_CTRL_MODE_BIT = 0;
    localparam int PCO_CTRL_OUTSEL_BIT = 1;
    localparam int PCO_CTRL_FUNC_LSB = 2;
    localparam int PCO_CTRL_FUNC_W = 2;
    localparam int PCO_CTRL_POL_BIT = 4;
    localparam int PCO_CTRL_W = 5;
    localparam logic [4:0] PCO_CTRL_RESET = 5'h10;

    // ==========================================================
    // command register bits, write-one pulses
    localparam int PCO_CMD_CLEAR_BIT = 0;
    localparam int PCO_CMD_START_BIT = 1;
    localparam int PCO_CMD_STOP_BIT = 2;

    // ==========================================================
    // status register bits
    localparam int PCO_STAT_OUT_BIT = 0;
    localparam int PCO_STAT_RUN_BIT = 1;
    localparam int PCO_STAT_HOLD_BIT = 2;
    localparam int PCO_STAT_PULSE_BIT = 3;

    // ==========================================================
    // input function codes and modes
    localparam logic [1:0] PCO_FUNC_NONE = 2'h0;
    localparam logic [1:0] PCO_FUNC_CLEAR_RUN = 2'h2;

    typedef enum logic [0:0] {
        PCO_MODE_LEVEL = 1'b0,
        PCO_MODE_ONESHOT = 1'b1
    } pco_mode_e;

    // ==========================================================
    // reset values and timing
    localparam logic [31:0] PCO_PRESET_COUNT_RESET = 32'h0000_0064;
    localparam logic [15:0] PCO_PULSE_WIDTH_RESET = 16'h0032;
    localparam int PCO_CLK_MHZ = 100;
    localparam int PCO_MS_NS = 1000000;
    localparam int PCO_CLK_PERIOD_NS = 1000 / PCO_CLK_MHZ;
    localparam int PCO_CYC_PER_MS = PCO_MS_NS / PCO_CLK_PERIOD_NS;

endpackage

// ==== pco_sync.sv ====
// ==========================================================
// two flip-flop synchroniser for a level from a pin
module pco_sync (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic pin_in,
    output logic level_out
);
    logic meta_r;
    logic level_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            level_r <= meta_r;
        end
    end

    assign level_out = level_r;
endmodule

// ==== pco_pulse_timer.sv ====
// ==========================================================
// one-shot width timer counted in milliseconds
module pco_pulse_timer #(
    parameter int CYC_PER_MS = 100000
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic start,
    input wire logic cancel,
    input wire logic [15:0] width_ms,
    output logic active
);
    logic [16:0] pre_r;
    logic [16:0] pre_nxt;
    logic [15:0] left_r;
    logic [15:0] left_nxt;
    logic ms_tick;

    // a zero width still gives one millisecond
    assign ms_tick = (pre_r == 17'(CYC_PER_MS - 1));
    assign pre_nxt = (start || ms_tick) ? 17'h0_0000 : pre_r + 17'h0_0001;
    assign left_nxt = cancel ? 16'h0000 :
                      start ? ((width_ms == 16'h0000) ? 16'h0001 : width_ms) :
                      (ms_tick && left_r != 16'h0000) ? left_r - 16'h0001 : left_r;

    // prescaler restarts with every trigger so the width is whole
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pre_r <= 17'h0_0000;
            left_r <= 16'h0000;
        end else begin
            pre_r <= pre_nxt;
            left_r <= left_nxt;
        end
    end

    assign active = (left_r != 16'h0000);
endmodule

// ==== pco_chk.sv ====
// ==========================================================
// port-level checker for the preset count output
module pco_chk
    import pco_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [pco_pkg::PCO_AW-1:0] reg_addr,
    input wire logic [pco_pkg::PCO_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pco_pkg::PCO_DW-1:0] reg_rdata,
    input wire logic external_control_input,
    input wire logic [pco_pkg::PCO_DW-1:0] nv_total_out,
    input wire logic nv_total_write,
    input wire logic contact_output_one,
    input wire logic contact_output_two
);
    import pco_pkg::*;
    logic [4:0] ctrl_r;
    logic [31:0] cnt_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // shadow copies of the control and preset count registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= PCO_CTRL_RESET;
            cnt_r <= PCO_PRESET_COUNT_RESET;
        end else if (reg_wr && reg_addr == PCO_OFF_CTRL) begin
            ctrl_r <= reg_wdata[4:0];
        end else if (reg_wr && reg_addr == PCO_OFF_PRESET_COUNT) begin
            cnt_r <= reg_wdata;
        end
    end

    // decoded conditions
    wire fn_w = ctrl_r[3:2] == PCO_FUNC_CLEAR_RUN;
    wire clr_hi = fn_w && ctrl_r[4] && external_control_input;
    wire clr_lo = fn_w && !ctrl_r[4] && !external_control_input;
    wire sel_w = ctrl_r[1] ? contact_output_two : contact_output_one;
    wire cmd_clr = reg_wr && reg_addr == PCO_OFF_CMD && reg_wdata[0];
    wire reach = !ctrl_r[0] && cnt_r > 1 && nv_total_out >= cnt_r;

    // ==========================================================
    // assertions
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_one_dest;
        !(contact_output_one && contact_output_two);
    endproperty
    a_one_dest: assert property (p_one_dest)
        else $error("both contact outputs on");
    property p_two_idle;
        (!ctrl_r[1] && $stable(ctrl_r))[*3] |-> !contact_output_two;
    endproperty
    a_two_idle: assert property (p_two_idle)
        else $error("output two on while not selected");
    property p_level_on;
        (reach && $stable(ctrl_r))[*4] |-> sel_w;
    endproperty
    a_level_on: assert property (p_level_on)
        else $error("level output off while point reached");
    property p_hi_clear;
        clr_hi[*5] |-> nv_total_out == '0;
    endproperty
    a_hi_clear: assert property (p_hi_clear)
        else $error("high pin did not hold total at zero");
    property p_lo_clear;
        clr_lo[*5] |-> nv_total_out == '0;
    endproperty
    a_lo_clear: assert property (p_lo_clear)
        else $error("low pin did not hold total at zero");
    property p_cmd_clear;
        cmd_clr && cnt_r > 1 |-> ##[1:2] nv_total_out == '0
            ##[0:3] !(contact_output_one || contact_output_two);
    endproperty
    a_cmd_clear: assert property (p_cmd_clear)
        else $error("local clear did not zero total and output");
    property p_nv_write;
        nv_total_write |-> $past(nv_total_out) != $past(nv_total_out, 2)
            || nv_total_out != $past(nv_total_out);
    endproperty
    a_nv_write: assert property (p_nv_write)
        else $error("store pulse without total change");
endmodule

// ==== pco_ext_ctl.sv ====
// ==========================================================
// external controller driving the clear/run pin
module pco_ext_ctl (
    input wire logic clk_sys,
    input wire logic want_clear,
    input wire logic pol_high,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin = 1'b0;
    // level follows the polarity the device is set to
    always @(posedge clk_sys) begin
        pin <= pol_high ? want_clear : !want_clear;
    end
endmodule

// ==== tb_top.sv ====
// ==========================================================
// self-checking bench
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pco_pkg::*;
    localparam int CPM = 10;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, nv_in = '0, d;
    logic reg_wr = 0, reg_rd = 0, count_tick = 0, nv_load = 0;
    logic want_clr = 0, pol_hi = 1, m_hold = 0, watch = 0;
    wire ext_pin, nv_wr, out1, out2;
    wire [31:0] rdata, nv_out;
    integer num_errors = 0, cmp_count = 0, seed = 63, m_total = 0, n, i, lows = 0;
    logic [7:0] ofs [0:6] = '{PCO_OFF_CTRL, PCO_OFF_PRESET_COUNT, PCO_OFF_PULSE_WIDTH,
        PCO_OFF_TOTAL, PCO_OFF_PRESET_POINT, 8'h1C, PCO_OFF_STATUS};
    // status after reset: running only
    logic [31:0] rv [0:6] = '{32'h10, 32'h64, 32'h32, 32'h0, 32'h64, 32'h0, 32'h2};

    always #5 clk_sys = ~clk_sys;
    // counts cycles where the held output dropped
    always @(posedge clk_sys) if (watch && out1 !== 1'b1) lows <= lows + 1;

    pco_ext_ctl ext_u (.clk_sys(clk_sys), .want_clear(want_clr), .pol_high(pol_hi),
        .pin(ext_pin));
    pco_preset_count_output #(.CYC_PER_MS(CPM)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .count_tick(count_tick), .external_control_input(ext_pin),
        .nv_total_in(nv_in), .nv_total_load(nv_load), .nv_total_out(nv_out),
        .nv_total_write(nv_wr), .contact_output_one(out1), .contact_output_two(out2));

    // ==========================================================
    // tasks
    task results;
        if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task chkb(input logic g, input logic e, input string m);
        chk({31'h0, g}, {31'h0, e}, m);
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = rdata;
    endtask
    task ctot;
        rd(PCO_OFF_TOTAL);
        chk(d, m_total, "total");
    endtask
    task tk(input integer k, input integer gap);
        repeat (k) begin
            @(posedge clk_sys);
            count_tick <= 1'b1;
            @(posedge clk_sys);
            count_tick <= 1'b0;
            if (!m_hold) m_total++;
            repeat (gap ? gap + ($random(seed) & 3) : 0) @(posedge clk_sys);
        end
    endtask
    task wt1(input logic v, input integer lim);
        n = 0;
        #1;
        while (out1 !== v && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= lim) begin
            num_errors++;
            results();
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        wr(PCO_OFF_TOTAL, 32'h55);
        wr(8'h1C, 32'hFF);
        for (i = 0; i < 7; i++) begin
            rd(ofs[i]);
            chk(d, rv[i], "reset map");
        end
        // level hold, output select, local clear
        wr(PCO_OFF_PRESET_COUNT, 32'h5);
        tk(4, 1);
        chkb(out1, 1'b0, "early");
        tk(1, 1);
        wt1(1'b1, 8);
        tk(3, 1);
        cyc(2);
        chkb(out1, 1'b1, "hold");
        rd(PCO_OFF_PRESET_POINT);
        chk(d, 32'h5, "level point");
        ctot();
        wr(PCO_OFF_CTRL, 32'h12);
        cyc(3);
        chkb(out2, 1'b1, "out two");
        chkb(out1, 1'b0, "out one");
        wr(PCO_OFF_CMD, 32'h1);
        m_total = 0;
        cyc(4);
        chkb(out2, 1'b0, "cleared");
        ctot();
        // pin clear, both polarities
        wr(PCO_OFF_CTRL, 32'h10);
        want_clr <= 1'b1;
        tk(2, 1);
        ctot();
        wr(PCO_OFF_CTRL, 32'h18);
        cyc(5);
        m_total = 0;
        m_hold = 1;
        tk(2, 1);
        ctot();
        want_clr <= 1'b0;
        cyc(5);
        m_hold = 0;
        tk(3, 1);
        ctot();
        wr(PCO_OFF_CTRL, 32'h00);
        pol_hi <= 1'b0;
        cyc(5);
        wr(PCO_OFF_CTRL, 32'h08);
        want_clr <= 1'b1;
        cyc(5);
        m_total = 0;
        m_hold = 1;
        tk(2, 1);
        ctot();
        want_clr <= 1'b0;
        cyc(5);
        m_hold = 0;
        tk(2, 1);
        ctot();
        wr(PCO_OFF_CTRL, 32'h10);
        pol_hi <= 1'b1;
        // one-shot width, advance, clear
        wr(PCO_OFF_CMD, 32'h1);
        m_total = 0;
        wr(PCO_OFF_PULSE_WIDTH, 32'h3);
        wr(PCO_OFF_CTRL, 32'h01);
        wr(PCO_OFF_PRESET_COUNT, 32'h5);
        tk(4, 12);
        tk(1, 0);
        wt1(1'b1, 8);
        wt1(1'b0, 60);
        chkb(n >= 3 * CPM - 2 && n <= 3 * CPM + 2, 1'b1, "width");
        rd(PCO_OFF_PRESET_POINT);
        chk(d, 32'hA, "point");
        tk(5, 12);
        rd(PCO_OFF_PRESET_POINT);
        chk(d, 32'hF, "point");
        wr(PCO_OFF_CMD, 32'h1);
        m_total = 0;
        cyc(4);
        chkb(out1, 1'b0, "cut");
        ctot();
        rd(PCO_OFF_PRESET_POINT);
        chk(d, 32'h5, "point");
        // long width keeps output on
        wr(PCO_OFF_PULSE_WIDTH, 32'h14);
        tk(5, 12);
        wt1(1'b1, 8);
        watch = 1;
        tk(15, 12);
        watch = 0;
        chk(lows, 0, "held");
        // stop, start, store load
        wr(PCO_OFF_CMD, 32'h4);
        m_hold = 1;
        tk(2, 1);
        ctot();
        wr(PCO_OFF_CMD, 32'h2);
        m_hold = 0;
        @(posedge clk_sys);
        nv_in <= $random(seed) & 32'hFF;
        nv_load <= 1'b1;
        @(posedge clk_sys);
        nv_load <= 1'b0;
        m_total = nv_in;
        ctot();
        tk(1, 1);
        cyc(1);
        chk(nv_out, m_total, "store");
        results();
    end
endmodule

bind pco_preset_count_output pco_chk chk_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_control_input(external_control_input),
    .nv_total_out(nv_total_out), .nv_total_write(nv_total_write),
    .contact_output_one(contact_output_one), .contact_output_two(contact_output_two));
